// file: rtl/bct_carry_test_unit.sv
// Carry test unit: compares, nonzero tests, flag input and low battery
`timescale 1ns/1ps
// Summary of operation
// - A not equal C over field sets carry, else clears; 56 cycles.
// - A less than B over field sets carry, else clears; 56 cycles.
// - A less than C over field sets carry, else clears; 56 cycles.
// - Any nonzero B digit in field sets carry, else clears.
// - Any nonzero C digit in field sets carry, else clears.
// - Flag test loads carry from flag input bit chosen by digit field.
// - Flag test runs at normal bus speed even in turbo mode.
// - Flag input sampled at second phase-one falling edge of digit.
// - Time-enable field picks the digit range per fixed table.
// - Digit field maps fourteen codes to digit times; 0111, 1111 illegal.
module bct_carry_test_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [9:0] instrWord,
  input wire logic [bct_pkg::WORD_W-1:0] regA,
  input wire logic [bct_pkg::WORD_W-1:0] regB,
  input wire logic [bct_pkg::WORD_W-1:0] regC,
  input wire logic [3:0] ptrP,
  input wire logic [3:0] ptrQ,
  input wire logic turboActive,
  input wire logic serialFlagInput,
  input wire logic lowLevelDetect_n,
  output logic carryFlag,
  output logic busy,
  output logic done,
  output logic phaseOneClock,
  output logic normalSpeedReq
);
  import bct_pkg::*;

  // One struct holds all state; a single copy is rebuilt every cycle
  // so no field can be left unassigned on some path
  typedef struct packed {
    bct_state_t state;
    bct_op_t op;
    logic [2:0] tef;
    logic [3:0] flagDigit;
    logic [WORD_W-1:0] opA;
    logic [WORD_W-1:0] opX;
    logic [3:0] ptrP;
    logic [3:0] ptrQ;
    logic [3:0] digit;
    logic [1:0] phase;
    logic acc;
    logic carry;
    logic busy;
    logic done;
    logic phaseOne;
    logic normal;
  } bct_st_t;

  bct_st_t st_r;
  bct_st_t st_nxt;
  logic flagSync;
  logic lowSync_n;

  // Both pins come from outside the clock domain
  bct_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinAsync({serialFlagInput, lowLevelDetect_n}),
    .pinSync({flagSync, lowSync_n})
  );

  logic isArith;
  logic [4:0] opc5;
  logic [3:0] digCode;
  logic digLegal;
  logic [3:0] nibA;
  logic [3:0] nibX;
  logic inField;
  logic lastStep;

  always_comb begin
    isArith = (instrWord[1:0] == CLASS_ARITH);
    opc5 = instrWord[9:5];
    digCode = instrWord[9:6];
    // The two spare digit codes belong to other instructions
    digLegal = (digCode != DIG_ILLEGAL_A) &&
               (digCode != DIG_ILLEGAL_B);
    nibA = st_r.opA[4*st_r.digit +: 4];
    nibX = st_r.opX[4*st_r.digit +: 4];
    inField = bct_in_field(st_r.tef, st_r.ptrP, st_r.ptrQ,
                           st_r.digit);
    lastStep = (st_r.digit == LAST_DIGIT) && (st_r.phase == LAST_PHASE);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.state)
      BCT_IDLE: begin
        // Unknown words leave the unit idle
        st_nxt.phaseOne = 1'b0;
        if (instrValid) begin
          st_nxt.op = BCT_OP_NONE;
          st_nxt.tef = instrWord[4:2];
          st_nxt.flagDigit = bct_digit_of(digCode);
          // Operands are copied; the source registers are never written
          st_nxt.opA = regA;
          st_nxt.opX = regC;
          st_nxt.ptrP = ptrP;
          st_nxt.ptrQ = ptrQ;
          if (isArith && opc5 == OPC_NE_AC) begin
            st_nxt.op = BCT_OP_NE;
          end else if (isArith && opc5 == OPC_LT_AB) begin
            st_nxt.op = BCT_OP_LT;
            st_nxt.opX = regB;
          end else if (isArith && opc5 == OPC_LT_AC) begin
            st_nxt.op = BCT_OP_LT;
          end else if (isArith && opc5 == OPC_NZ_B) begin
            st_nxt.op = BCT_OP_NZ;
            st_nxt.opA = regB;
          end else if (isArith && opc5 == OPC_NZ_C) begin
            st_nxt.op = BCT_OP_NZ;
            st_nxt.opA = regC;
          end else if (instrWord[5:0] == OPC_FLAG_LOW && digLegal) begin
            st_nxt.op = BCT_OP_FLAG;
          end else if (instrWord == OPC_LLD) begin
            st_nxt.op = BCT_OP_LLD;
          end
          if (st_nxt.op != BCT_OP_NONE) begin
            st_nxt.state = BCT_RUN;
            st_nxt.busy = 1'b1;
            st_nxt.digit = 4'h0;
            st_nxt.phase = 2'h0;
            st_nxt.acc = 1'b0;
            st_nxt.phaseOne = 1'b1;
            // Peripherals need a full-length digit time to answer
            st_nxt.normal = turboActive && (st_nxt.op == BCT_OP_FLAG);
          end
        end
      end
      BCT_RUN: begin
        // Four clocks make one digit time
        st_nxt.phase = st_r.phase + 2'h1;
        if (st_r.phase == LAST_PHASE) begin
          st_nxt.digit = st_r.digit + 4'h1;
        end
        st_nxt.phaseOne = (st_nxt.phase == PHASE_ONE_HIGH_A) ||
                          (st_nxt.phase == PHASE_ONE_HIGH_B);
        // Each digit is judged where its second phase-one pulse falls;
        // the flag pin has by then passed the two synchroniser stages
        if (st_r.phase == FLAG_SAMPLE_PHASE) begin
          case (st_r.op)
            BCT_OP_NE: begin
              if (inField && nibA != nibX) begin
                st_nxt.acc = 1'b1;
              end
            end
            BCT_OP_LT: begin
              // Serial borrow from the least significant digit up
              if (inField) begin
                st_nxt.acc = (nibA < nibX) ||
                             ((nibA == nibX) && st_r.acc);
              end
            end
            BCT_OP_NZ: begin
              if (inField && nibA != 4'h0) begin
                st_nxt.acc = 1'b1;
              end
            end
            BCT_OP_FLAG: begin
              // Only the chosen digit time loads carry
              if (st_r.digit == st_r.flagDigit) begin
                st_nxt.acc = flagSync;
              end
            end
            BCT_OP_LLD: begin
              // Every digit resamples; the last one before the end wins
              st_nxt.acc = ~lowSync_n;
            end
            default: begin
              st_nxt.acc = st_r.acc;
            end
          endcase
        end
        // Carry moves only here, so refused words never touch it
        if (lastStep) begin
          st_nxt.state = BCT_IDLE;
          st_nxt.carry = st_nxt.acc;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.normal = 1'b0;
          st_nxt.phaseOne = 1'b0;
          // Keeps the idle digit index inside the operand word
          st_nxt.digit = 4'h0;
        end
      end
      default: begin
        // A corrupt state code falls back to idle; carry is kept
        st_nxt.state = BCT_IDLE;
        st_nxt.busy = 1'b0;
        st_nxt.normal = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= BCT_IDLE;
      st_r.op <= BCT_OP_NONE;
      st_r.carry <= RST_CARRY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are plain register fields, with no logic after the flops
  assign carryFlag = st_r.carry;
  assign busy = st_r.busy;
  assign done = st_r.done;
  assign phaseOneClock = st_r.phaseOne;
  assign normalSpeedReq = st_r.normal;

endmodule : bct_carry_test_unit

// file: rtl/bct_pkg.sv
// Shared constants, types and decoders for the carry test unit
package bct_pkg;

  localparam int DIGITS = 14;
  localparam int WORD_W = 56;
  localparam logic [3:0] LAST_DIGIT = 4'hD;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  // Phase one is high in phases 0 and 2; its second pulse falls as
  // phase 2 ends, so every digit is judged at that edge
  localparam logic [1:0] FLAG_SAMPLE_PHASE = 2'h2;
  localparam logic [1:0] PHASE_ONE_HIGH_A = 2'h0;
  localparam logic [1:0] PHASE_ONE_HIGH_B = 2'h2;

  // Instruction decode fields
  localparam logic [1:0] CLASS_ARITH = 2'h2;
  localparam logic [4:0] OPC_NE_AC = 5'h1B;
  localparam logic [4:0] OPC_LT_AB = 5'h19;
  localparam logic [4:0] OPC_LT_AC = 5'h18;
  localparam logic [4:0] OPC_NZ_B = 5'h16;
  localparam logic [4:0] OPC_NZ_C = 5'h17;
  localparam logic [5:0] OPC_FLAG_LOW = 6'h2C;
  localparam logic [9:0] OPC_LLD = 10'h160;
  localparam logic [3:0] DIG_ILLEGAL_A = 4'h7;
  localparam logic [3:0] DIG_ILLEGAL_B = 4'hF;

  // Time enable field codes
  localparam logic [2:0] TEF_PT = 3'h0;
  localparam logic [2:0] TEF_X = 3'h1;
  localparam logic [2:0] TEF_WPT = 3'h2;
  localparam logic [2:0] TEF_W = 3'h3;
  localparam logic [2:0] TEF_PQ = 3'h4;
  localparam logic [2:0] TEF_XS = 3'h5;
  localparam logic [2:0] TEF_M = 3'h6;
  localparam logic [2:0] TEF_S = 3'h7;
  localparam logic [3:0] EXP_SIGN_DIGIT = 4'h2;
  localparam logic [3:0] MANT_LOW_DIGIT = 4'h3;
  localparam logic [3:0] MANT_HIGH_DIGIT = 4'hC;
  localparam logic [3:0] MANT_SIGN_DIGIT = 4'hD;

  localparam logic RST_CARRY = 1'b0;

  typedef enum logic [1:0] {
    BCT_IDLE = 2'b01,
    BCT_RUN = 2'b10
  } bct_state_t;

  typedef enum logic [6:0] {
    BCT_OP_NONE = 7'h00,
    BCT_OP_NE = 7'h01,
    BCT_OP_LT = 7'h02,
    BCT_OP_NZ = 7'h04,
    BCT_OP_FLAG = 7'h08,
    BCT_OP_LLD = 7'h10,
    BCT_OP_RSV0 = 7'h20,
    BCT_OP_RSV1 = 7'h40
  } bct_op_t;

  // Digit-number field to digit time
  function automatic logic [3:0] bct_digit_of(input logic [3:0] code);
    case (code)
      4'h0: bct_digit_of = 4'h3;
      4'h1: bct_digit_of = 4'h4;
      4'h2: bct_digit_of = 4'h5;
      4'h3: bct_digit_of = 4'hA;
      4'h4: bct_digit_of = 4'h8;
      4'h5: bct_digit_of = 4'h6;
      4'h6: bct_digit_of = 4'hB;
      4'h8: bct_digit_of = 4'h2;
      4'h9: bct_digit_of = 4'h9;
      4'hA: bct_digit_of = 4'h7;
      4'hB: bct_digit_of = 4'hD;
      4'hC: bct_digit_of = 4'h1;
      4'hD: bct_digit_of = 4'hC;
      4'hE: bct_digit_of = 4'h0;
      default: bct_digit_of = 4'h0;
    endcase
  endfunction : bct_digit_of

  // True when digit d lies inside the field chosen by tef
  function automatic logic bct_in_field(input logic [2:0] tef,
                                        input logic [3:0] p,
                                        input logic [3:0] q,
                                        input logic [3:0] d);
    case (tef)
      TEF_PT: bct_in_field = (d == p);
      TEF_X: bct_in_field = (d <= EXP_SIGN_DIGIT);
      TEF_WPT: bct_in_field = (d <= p);
      TEF_W: bct_in_field = 1'b1;
      // A reversed pair runs from P up to the top digit
      TEF_PQ: bct_in_field = (p <= q) ? (d >= p && d <= q) : (d >= p);
      TEF_XS: bct_in_field = (d == EXP_SIGN_DIGIT);
      TEF_M: bct_in_field = (d >= MANT_LOW_DIGIT && d <= MANT_HIGH_DIGIT);
      TEF_S: bct_in_field = (d == MANT_SIGN_DIGIT);
      default: bct_in_field = 1'b0;
    endcase
  endfunction : bct_in_field

endpackage : bct_pkg

// file: rtl/bct_sync.sv
// Two-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
module bct_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinSync
);
  import bct_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bct_sync_st_t;

  bct_sync_st_t st_r;
  bct_sync_st_t st_nxt;

  always_comb begin
    st_nxt.meta = pinAsync;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinSync = st_r.stable;

endmodule : bct_sync

// file: tb/bct_carry_checker.sv
// Port assertions for the carry test unit
`timescale 1ns/1ps
module bct_carry_checker
  import bct_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [9:0] instrWord,
  input wire logic turboActive,
  input wire logic carryFlag,
  input wire logic busy,
  input wire logic done,
  input wire logic phaseOneClock,
  input wire logic normalSpeedReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic flagTake;
  assign flagTake = instrValid && !busy && instrWord[5:0] == OPC_FLAG_LOW
    && instrWord[9:6] != DIG_ILLEGAL_A && instrWord[9:6] != DIG_ILLEGAL_B;
  done_end_a: assert property ($rose(busy) |-> ##55 busy ##1
    (done && !busy))
    else $error("test did not end after 56 cycles");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  carry_hold_a: assert property ($changed(carryFlag) |-> done)
    else $error("carry moved outside completion");
  take_a: assert property (instrValid && !busy &&
    instrWord == OPC_LLD |=> busy)
    else $error("low battery test not taken");
  nsr_a: assert property (flagTake && turboActive |=> normalSpeedReq)
    else $error("flag test not slowed in turbo");
  nsr_busy_a: assert property (normalSpeedReq |-> busy)
    else $error("slow request outside a test");
  phase_idle_a: assert property (!busy |-> !phaseOneClock)
    else $error("phase one clock while idle");
  phase_form_a: assert property ($rose(busy) |-> phaseOneClock ##1
    !phaseOneClock ##1 phaseOneClock ##1 !phaseOneClock)
    else $error("phase one pattern wrong");
  cover property (done && carryFlag);
  cover property (normalSpeedReq);
  cover property ($fell(busy) && !carryFlag);
endmodule : bct_carry_checker

bind bct_carry_test_unit bct_carry_checker u_chk (.clk_sys(clk_sys),
  .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
  .turboActive(turboActive), .carryFlag(carryFlag), .busy(busy),
  .done(done), .phaseOneClock(phaseOneClock),
  .normalSpeedReq(normalSpeedReq));

// file: tb/bct_flag_peripheral.sv
// Peripheral model that serialises flag bits onto the flag input
`timescale 1ns/1ps
module bct_flag_peripheral (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busy,
  input wire logic [13:0] flagBits,
  output logic serialFlagInput
);
  logic [5:0] cyc_r;
  logic tog_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyc_r <= 6'h00;
      tog_r <= 1'b0;
    end else begin
      cyc_r <= busy ? cyc_r + 6'h01 : 6'h00;
      tog_r <= ~tog_r;
    end
  end
  // Held over the whole digit time; idle line wanders so stale bits show
  assign serialFlagInput = busy ? flagBits[cyc_r[5:2]] : tog_r;
endmodule : bct_flag_peripheral

// file: tb/bct_carry_test_unit_tb.sv
// Self-checking bench for the carry test unit
`timescale 1ns/1ps
module bct_carry_test_unit_tb;
  import bct_pkg::*;
  // Digit time for each digit code, code 0 in the low nibble
  localparam logic [63:0] DTIME = 64'h00C1D7920B68A543;
  logic clk_sys = 1'b0, rst = 1'b1, instrValid = 1'b0, turboActive = 1'b0;
  logic lowLevelDetect_n = 1'b1, serialFlagInput, carryFlag, busy, done;
  logic phaseOneClock, normalSpeedReq, sn, carryExp = 1'b0, tu = 1'b0;
  logic lv = 1'b1;
  logic [9:0] instrWord = 10'h000;
  logic [55:0] regA = 56'h0, regB = 56'h0, regC = 56'h0, a, b, c;
  logic [3:0] ptrP = 4'h0, ptrQ = 4'h0, p, q;
  logic [13:0] fl = 14'h0000;
  int error_cnt = 0, comparisons = 0;
  bct_carry_test_unit uut (.clk_sys(clk_sys), .rst(rst),
    .instrValid(instrValid), .instrWord(instrWord), .regA(regA),
    .regB(regB), .regC(regC), .ptrP(ptrP), .ptrQ(ptrQ),
    .turboActive(turboActive), .serialFlagInput(serialFlagInput),
    .lowLevelDetect_n(lowLevelDetect_n), .carryFlag(carryFlag),
    .busy(busy), .done(done), .phaseOneClock(phaseOneClock),
    .normalSpeedReq(normalSpeedReq));
  bct_flag_peripheral periph (.clk_sys(clk_sys), .rst(rst), .busy(busy),
    .flagBits(fl), .serialFlagInput(serialFlagInput));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic inf(logic [2:0] t, logic [3:0] d);
    case (t)
      3'h0: return d == p;
      3'h1: return d <= 4'h2;
      3'h2: return d <= p;
      3'h3: return 1'b1;
      3'h4: return p <= q ? d >= p && d <= q : d >= p;
      3'h5: return d == 4'h2;
      3'h6: return d >= 4'h3 && d <= 4'hC;
      default: return d == 4'hD;
    endcase
  endfunction : inf
  function automatic logic model(logic [9:0] w);
    logic ne, nb, nc, lb, lc;
    logic [3:0] x, y, z;
    {ne, nb, nc, lb, lc} = 5'h00;
    for (int d = 0; d < 14; d++) begin
      if (inf(w[4:2], d[3:0])) begin
        x = a[4*d+:4];
        y = b[4*d+:4];
        z = c[4*d+:4];
        ne |= x != z;
        nb |= y != 4'h0;
        nc |= z != 4'h0;
        // Borrow ripples up from the least significant digit
        lb = x < y || (x == y && lb);
        lc = x < z || (x == z && lc);
      end
    end
    case (w[9:5])
      5'h1B: return ne;
      5'h19: return lb;
      5'h18: return lc;
      5'h16: return nb;
      default: return nc;
    endcase
  endfunction : model
  task automatic run(logic [9:0] w, logic e, logic ok, logic pk);
    int n;
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= w;
    {regA, regB, regC, ptrP, ptrQ} <= {a, b, c, p, q};
    turboActive <= tu;
    lowLevelDetect_n <= lv;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    #1 sn = normalSpeedReq;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      // A second request in mid-test must be dropped
      instrValid <= pk && n == 9;
      #1 n++;
    end
    chk("cycles", n[7:0], ok ? 8'h38 : 8'h3C);
    if (ok) carryExp = e;
    chk("carry", carryFlag, carryExp);
  endtask : run
  task automatic t_cmp;
    logic [4:0] ops [5] = '{5'h1B, 5'h19, 5'h18, 5'h16, 5'h17};
    logic [9:0] w;
    for (int s = 0; s < 2; s++) begin
      {a, b, c} = s ? {56'h02340678900234, 56'h0, 56'h12345678901234}
        : {56'h12345678901234, 56'h12345678901299, 56'h02340678900234};
      {p, q} = s ? 8'h94 : 8'h49;
      for (int o = 0; o < 5; o++) begin
        for (int t = 0; t < 8; t++) begin
          w = {ops[o], t[2:0], 2'b10};
          run(w, model(w), 1'b1, 1'b0);
        end
      end
    end
  endtask : t_cmp
  task automatic t_flag;
    logic [3:0] k;
    for (int s = 0; s < 32; s++) begin
      k = s[3:0];
      fl = s[4] ? 14'h2B5C : 14'h14A3;
      tu = k[0];
      if (k != 4'h7 && k != 4'hF) begin
        run({k, 6'h2C}, fl[DTIME[4*k+:4]], 1'b1, 1'b0);
        chk("slow", sn, k[0]);
      end
    end
  endtask : t_flag
  task automatic t_lld;
    // Turbo must not slow any test but the flag test
    tu = 1'b1;
    for (int v = 0; v < 2; v++) begin
      lv = v[0];
      run(OPC_LLD, !v[0], 1'b1, 1'b0);
      chk("slow", sn, 8'h00);
    end
  endtask : t_lld
  task automatic t_refuse;
    lv = 1'b0;
    run(OPC_LLD, 1'b1, 1'b1, 1'b1);
    lv = 1'b1;
    run(10'h1EC, 1'b0, 1'b0, 1'b0);
    run(10'h3EC, 1'b0, 1'b0, 1'b0);
  endtask : t_refuse
  task automatic t_reset;
    // Reset in mid-test drops the test and clears carry
    lv = 1'b0;
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= OPC_LLD;
    lowLevelDetect_n <= lv;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("reset", {busy, done, phaseOneClock, normalSpeedReq, carryFlag},
      8'h00);
    carryExp = 1'b0;
    run(OPC_LLD, 1'b1, 1'b1, 1'b0);
  endtask : t_reset
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #2000000;
    error_cnt++;
    summarize;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_cmp;
    t_flag;
    t_lld;
    t_refuse;
    t_reset;
    summarize;
  end
endmodule : bct_carry_test_unit_tb
